// *** rtl/mcd_data_set.sv ***
// monitor command data set: network words to serial equipment lines
`timescale 1ns/1ns
module mcd_data_set (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // cycle marker from network logic, one-cycle pulse
   input wire logic frame_start,
   // command words from network
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [mcd_pkg::WORD_W-1:0] cmd_word,
   // monitor words to network
   output logic mon_valid,
   input wire logic mon_ready,
   output logic [mcd_pkg::WORD_W-1:0] mon_word,
   // serial equipment side
   output logic ser_clk,
   output logic [mcd_pkg::SUB_W-1:0] sub_addr,
   output logic [mcd_pkg::N_CMD-1:0] cmd_frame,
   output logic [mcd_pkg::N_CMD-1:0] cmd_sdata,
   output logic mon_active,
   output logic [3:0] mon_line,
   output logic [2:0] adc_chan,
   input wire logic [mcd_pkg::N_DIG-1:0] dig_in,
   input wire logic adc_sdata
);
   // state and serial engine
   mcd_pkg::mcd_state_t state_reg;
   logic is_mon_reg; // current shift is a monitor read
   logic [3:0] half_cnt_reg; // cycles within half bit
   logic [4:0] bit_cnt_reg; // bits done in word
   logic [mcd_pkg::DATA_W-1:0] shift_reg; // serial shifter
   logic [1:0] c_line_reg; // command line in use
   // monitor sequencing
   logic [1:0] mon_pend_reg; // words still owed this cycle
   logic [7:0] rom_idx_reg; // index into rom list
   logic [7:0] scan_reg; // ascending scan address
   logic fix_en_reg; // second word address frozen
   logic [7:0] fix_addr_reg; // frozen address
   logic [7:0] mon_addr_reg; // address of word in flight
   // input synchronisers
   logic [mcd_pkg::N_DIG:0] sync1_reg;
   logic [mcd_pkg::N_DIG:0] sync2_reg;

   // fifo between network and serial engine
   wire fifo_valid;
   wire [mcd_pkg::WORD_W-1:0] fifo_word;
   wire fifo_pop;

   mcd_fifo #(
      .WIDTH(mcd_pkg::WORD_W),
      .DEPTH(mcd_pkg::FIFO_DEPTH)
   ) u_cmd_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_word)
   );

   // command word decode
   wire [mcd_pkg::DATA_W-1:0] c_data =
      fifo_word[mcd_pkg::DATA_LSB +: mcd_pkg::DATA_W];
   wire [mcd_pkg::ADDR_W-1:0] c_addr =
      fifo_word[mcd_pkg::ADDR_LSB +: mcd_pkg::ADDR_W];
   wire [mcd_pkg::PAR_W-1:0] c_par = fifo_word[mcd_pkg::PAR_W-1:0];
   wire [mcd_pkg::SUB_W-1:0] c_sub = c_addr[mcd_pkg::SUB_W-1:0];
   wire [1:0] c_line = c_addr[mcd_pkg::CMD_LINE_LSB +: 2];
   wire c_par_ok = (c_par == mcd_pkg::mcd_parity({c_data, c_addr}));
   wire c_ctrl = (c_line == mcd_pkg::LINE_CTRL);
   wire [7:0] c_fix_addr = c_data[7:0];
   wire c_fix_ok = (c_fix_addr <= mcd_pkg::MON_LAST);
   wire idle = (state_reg == mcd_pkg::ST_IDLE);
   // commands go ahead of monitor reads
   assign fifo_pop = idle && fifo_valid;
   wire start_cmd = fifo_pop && c_par_ok && !c_ctrl;
   wire start_mon = idle && !fifo_valid && (mon_pend_reg != 2'd0);

   // rom list: a fixed permutation of the 192 addresses
   wire [10:0] rom_prod = 11'(rom_idx_reg) * 11'(mcd_pkg::ROM_STEP);
   wire [7:0] rom_addr = 8'(rom_prod % (11'(mcd_pkg::MON_LAST) + 11'h001));
   // source address chosen by the unit
   wire second_word = (mon_pend_reg == 2'd1);
   wire [7:0] scan_or_fix = fix_en_reg ? fix_addr_reg : scan_reg;
   wire [7:0] next_mon_addr = second_word ? scan_or_fix : rom_addr;
   wire [3:0] next_line = next_mon_addr[7:4];
   wire next_is_ana = (next_mon_addr >= mcd_pkg::ANA_BASE);

   // serial timing
   wire half_tick = (state_reg == mcd_pkg::ST_SHIFT) &&
                    (half_cnt_reg == mcd_pkg::HALF_LAST);
   wire rise_tick = half_tick && !ser_clk;
   wire fall_tick = half_tick && ser_clk;
   wire last_bit = (bit_cnt_reg == mcd_pkg::BIT_LAST);
   wire mon_is_ana = (mon_line >= mcd_pkg::ANA_LINE0);
   wire dig_bit = sync2_reg[mon_line[1:0]];
   wire in_bit = is_mon_reg ? (mon_is_ana ? sync2_reg[mcd_pkg::N_DIG] :
                 dig_bit) : 1'b0;
   wire [mcd_pkg::DATA_W-1:0] shift_next =
      {shift_reg[mcd_pkg::DATA_W-2:0], in_bit};
   wire word_done = fall_tick && last_bit;

   wire [mcd_pkg::ADDR_W-1:0] m_addr = {8'h00, mon_addr_reg};
   wire [mcd_pkg::BODY_W-1:0] m_body = {shift_next, m_addr};
   wire [mcd_pkg::WORD_W-1:0] m_word =
      {m_body, mcd_pkg::mcd_parity(m_body)};

   // two-flop synchronisers for equipment inputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {adc_sdata, dig_in};
         sync2_reg <= sync1_reg;
      end
   end

   // main sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= mcd_pkg::ST_IDLE;
      else
      begin
         unique case (state_reg)
            mcd_pkg::ST_IDLE:
               if (start_cmd || start_mon)
                  state_reg <= mcd_pkg::ST_SHIFT;
            mcd_pkg::ST_SHIFT:
               if (word_done)
                  state_reg <= is_mon_reg ? mcd_pkg::ST_SEND :
                               mcd_pkg::ST_IDLE;
            mcd_pkg::ST_SEND:
               if (mon_ready)
                  state_reg <= mcd_pkg::ST_IDLE;
         endcase
      end
   end

   // divider producing the serial clock, halves of 80 ns
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half_cnt_reg <= '0;
         ser_clk <= 1'b0;
         bit_cnt_reg <= '0;
      end
      else if (state_reg != mcd_pkg::ST_SHIFT)
      begin
         half_cnt_reg <= '0;
         ser_clk <= 1'b0;
         bit_cnt_reg <= '0;
      end
      else
      begin
         half_cnt_reg <= half_tick ? 4'h0 : half_cnt_reg + 4'h1;
         if (half_tick)
            ser_clk <= !ser_clk;
         if (fall_tick)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // 24-bit shifter and command data lines
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_reg <= '0;
         cmd_sdata <= '0;
         is_mon_reg <= 1'b0;
      end
      else if (start_cmd)
      begin
         // payload routed to addressed line, msb first
         shift_reg <= c_data;
         cmd_sdata <= 3'(c_data[mcd_pkg::DATA_W-1]) << c_line;
         is_mon_reg <= 1'b0;
      end
      else if (start_mon)
      begin
         shift_reg <= '0;
         cmd_sdata <= '0;
         is_mon_reg <= 1'b1;
      end
      else if (fall_tick)
      begin
         // data changes on falling edge, equipment samples on rising
         shift_reg <= shift_next;
         cmd_sdata <= (last_bit || is_mon_reg) ? 3'b000 :
                      (3'(shift_next[mcd_pkg::DATA_W-1]) << c_line_reg);
      end
   end

   // line frame and sub-address, held for the whole word
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c_line_reg <= '0;
         cmd_frame <= '0;
         sub_addr <= '0;
         mon_active <= 1'b0;
         mon_line <= '0;
         adc_chan <= '0;
      end
      else if (start_cmd)
      begin
         c_line_reg <= c_line;
         cmd_frame <= 3'b001 << c_line;
         sub_addr <= c_sub;
      end
      else if (start_mon)
      begin
         // select line, sub-address and converter channel
         mon_active <= 1'b1;
         mon_line <= next_line;
         sub_addr <= next_mon_addr[3:0];
         adc_chan <= next_is_ana ? 3'(next_line - mcd_pkg::ANA_LINE0) :
                     3'b000;
      end
      else if (word_done)
      begin
         cmd_frame <= '0;
         mon_active <= 1'b0;
      end
   end

   // two monitor words per cycle; address pointers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mon_pend_reg <= '0;
         rom_idx_reg <= '0;
         scan_reg <= '0;
         fix_en_reg <= 1'b0;
         fix_addr_reg <= '0;
         mon_addr_reg <= '0;
      end
      else
      begin
         if (frame_start)
            mon_pend_reg <= 2'd2;
         else if (start_mon)
            mon_pend_reg <= mon_pend_reg - 2'd1;
         if (start_mon)
            mon_addr_reg <= next_mon_addr;
         // rom index wraps after the last entry
         if (start_mon && !second_word)
            rom_idx_reg <= (rom_idx_reg == mcd_pkg::MON_LAST) ? 8'h00 :
                           rom_idx_reg + 8'h01;
         // scan steps even while frozen so release resumes in order
         if (start_mon && second_word)
            scan_reg <= (scan_reg == mcd_pkg::MON_LAST) ? 8'h00 :
                        scan_reg + 8'h01;
         // control command freezes or releases second address
         if (fifo_pop && c_par_ok && c_ctrl && c_fix_ok)
         begin
            fix_en_reg <= c_data[mcd_pkg::FIX_EN_BIT];
            fix_addr_reg <= c_fix_addr;
         end
      end
   end

   // monitor word out; analog words carry two 12-bit results
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mon_valid <= 1'b0;
         mon_word <= '0;
      end
      else if (word_done && is_mon_reg)
      begin
         mon_valid <= 1'b1;
         mon_word <= m_word;
      end
      else if (mon_valid && mon_ready)
         mon_valid <= 1'b0;
   end
endmodule // mcd_data_set

// *** pkg/mcd_pkg.sv ***
// shared constants, word layout and types for the monitor command data set
package mcd_pkg;
   // network word layout: 24 payload, 16 address, 5 parity bits
   localparam int WORD_W = 45;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 16;
   localparam int PAR_W = 5;
   localparam int DATA_LSB = 21;
   localparam int ADDR_LSB = 5;
   localparam int BODY_W = DATA_W + ADDR_W;
   // equipment side sizes
   localparam int SUB_W = 4;
   localparam int N_CMD = 3;
   localparam int N_DIG = 4;
   localparam int N_ANA = 8;
   localparam int ADC_W = 12;
   localparam int FIFO_DEPTH = 8;
   // command address field positions
   localparam int CMD_LINE_LSB = 4;
   localparam logic [1:0] LINE_CTRL = 2'h3;
   // internal control command payload
   localparam int FIX_EN_BIT = 8;
   // monitor address space: 4 digital then 8 analog lines of 16
   localparam logic [7:0] MON_LAST = 8'h00BF;
   localparam logic [7:0] ANA_BASE = 8'h0040;
   localparam logic [7:0] ROM_STEP = 8'h0007;
   localparam logic [3:0] ANA_LINE0 = 4'h4;
   localparam logic [4:0] BIT_LAST = 5'h17;
   // serial clock timing
   localparam int CLK_NS = 8;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF = SCLK_PERIOD_NS / (2 * CLK_NS);
   localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF - 1);

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_SEND} mcd_state_t;

   // five interleaved parity bits over payload and address
   function automatic logic [PAR_W-1:0] mcd_parity(
      input logic [BODY_W-1:0] body);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int i = 0; i < BODY_W; i++)
         p[i % PAR_W] = p[i % PAR_W] ^ body[i];
      return p;
   endfunction
endpackage

// *** rtl/mcd_fifo.sv ***
// parameterised valid/ready word fifo
`timescale 1ns/1ns
module mcd_fifo #(
   parameter int WIDTH = 45,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH]; // word storage
   logic [PW-1:0] wr_ptr_reg; // next slot to write
   logic [PW-1:0] rd_ptr_reg; // next slot to read
   logic [PW:0] count_reg; // words held
   logic not_full_reg; // registered room flag, drives in_ready
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // occupancy after this edge
   wire [PW:0] count_next = (push && !pop) ? count_reg + 1'b1 :
                            (pop && !push) ? count_reg - 1'b1 : count_reg;

   // room flag comes from a flop so the top output is registered
   assign in_ready = not_full_reg;
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];

   // storage write, no reset needed
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   // pointers and occupancy
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         not_full_reg <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         count_reg <= count_next;
         not_full_reg <= (count_next != CNT_FULL);
      end
   end
endmodule // mcd_fifo

// *** tb/mcd_data_set_properties.sv ***
// port checker for the monitor command data set
`timescale 1ns/1ns
module mcd_data_set_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // monitor port
   input wire logic mon_valid,
   input wire logic mon_ready,
   input wire logic [44:0] mon_word,
   // serial side
   input wire logic ser_clk,
   input wire logic [3:0] sub_addr,
   input wire logic [2:0] cmd_frame,
   input wire logic [2:0] cmd_sdata,
   input wire logic mon_active,
   input wire logic [3:0] mon_line,
   input wire logic [2:0] adc_chan
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a serial word is in flight
   wire cmd_on = |cmd_frame;
   wire busy = cmd_on | mon_active;
   logic sclk_reg;
   logic [5:0] rise_reg;
   // pulse count restarts between words
   wire [5:0] rise_next = busy ? rise_reg + 6'(ser_clk & ~sclk_reg) : 6'h00;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         sclk_reg <= 1'b0;
         rise_reg <= 6'h00;
      end
      else
      begin
         sclk_reg <= ser_clk;
         rise_reg <= rise_next;
      end
   // high half of one serial clock period
   sequence s_high;
      ser_clk [*8] ##1 ser_clk [*2];
   endsequence
   property p_half;
      $rose(ser_clk) |-> s_high ##1 !ser_clk;
   endproperty
   property p_idle;
      !busy |-> !ser_clk;
   endproperty
   property p_cstable;
      cmd_on && $past(cmd_on) |-> $stable({cmd_frame, sub_addr});
   endproperty
   property p_mstable;
      mon_active && $past(mon_active) |->
         $stable({mon_line, sub_addr, adc_chan});
   endproperty
   property p_onehot;
      $onehot0(cmd_frame) && !(cmd_on && mon_active);
   endproperty
   property p_edge;
      cmd_on && $past(cmd_on) && $changed(cmd_sdata) |-> $fell(ser_clk);
   endproperty
   property p_count;
      $fell(busy) |-> rise_reg == 6'h18;
   endproperty
   property p_hold;
      mon_valid && !mon_ready |=> mon_valid && $stable(mon_word);
   endproperty
   property p_take;
      mon_valid && mon_ready |=> !mon_valid;
   endproperty
   property p_chan;
      mon_active |-> mon_line <= 4'hB && adc_chan ==
         (mon_line[3:2] != 2'h0 ? 3'(mon_line - 4'h4) : 3'h0);
   endproperty
   // five interleaved parity bits over payload and address
   function automatic logic [4:0] wpar(input logic [39:0] b);
      logic [4:0] p;
      p = '0;
      for (int i = 0; i < 40; i++)
         p[i % 5] ^= b[i];
      return p;
   endfunction
   property p_addr;
      mon_valid |-> mon_word[20:13] == 8'h00 && mon_word[12:5] <= 8'hBF &&
         mon_word[4:0] == wpar(mon_word[44:5]);
   endproperty
   a_half: assert property (p_half)
      else $error("serial clock half period wrong");
   a_idle: assert property (p_idle)
      else $error("serial clock runs while idle");
   a_cstable: assert property (p_cstable)
      else $error("command line or sub-address moved");
   a_mstable: assert property (p_mstable)
      else $error("monitor source moved in a word");
   a_onehot: assert property (p_onehot)
      else $error("more than one word active");
   a_edge: assert property (p_edge)
      else $error("command data changed off falling edge");
   a_count: assert property (p_count)
      else $error("word did not carry 24 clock pulses");
   a_hold: assert property (p_hold)
      else $error("monitor word dropped before taken");
   a_take: assert property (p_take)
      else $error("monitor valid held after take");
   a_chan: assert property (p_chan)
      else $error("converter channel wrong");
   a_addr: assert property (p_addr)
      else $error("monitor address or parity wrong");
endmodule // mcd_data_set_properties

// *** tb/mcd_equip_model.sv ***
// equipment modules answering on the serial monitor lines
`timescale 1ns/1ns
module mcd_equip_model (
   // serial side from the unit
   input wire logic ser_clk,
   input wire logic mon_active,
   input wire logic [3:0] mon_line,
   input wire logic [3:0] sub_addr,
   // monitor data back to the unit
   output logic [3:0] dig_in,
   output logic adc_sdata
);
   logic [23:0] word_reg;
   logic bit_reg = 1'b0;
   int k = 0;
   // source data, two 12-bit results on analog lines
   function automatic logic [23:0] pat(input logic [7:0] a);
      return (a < 8'h40) ? {a, ~a, a} : {4'hA, a, 4'h5, a};
   endfunction
   // shift only on the supplied clock, msb first
   always @(posedge ser_clk or negedge mon_active)
      if (!mon_active)
      begin
         // released line shows inverse of last bit
         bit_reg = ~bit_reg;
         k = 0;
      end
      else if (k < 24)
      begin
         if (k == 0)
            word_reg = pat({mon_line, sub_addr});
         bit_reg = word_reg[23 - k];
         k = k + 1;
      end
   // the selected line carries data, and on analog reads so does digital line mon_line[1:0]
   assign dig_in = {4{bit_reg}} ^ ~(4'h1 << mon_line[1:0]);
   assign adc_sdata = (mon_line >= 4'h4) ? bit_reg : ~bit_reg;
endmodule // mcd_equip_model

// *** tb/mcd_data_set_tb_top.sv ***
// self-checking bench for the monitor command data set
`timescale 1ns/1ns
module mcd_data_set_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic frame_start = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [mcd_pkg::WORD_W-1:0] cmd_word = '0;
   logic mon_valid;
   logic mon_ready = 1'b0;
   logic [mcd_pkg::WORD_W-1:0] mon_word;
   logic ser_clk;
   logic mon_active;
   logic [3:0] sub_addr;
   logic [3:0] mon_line;
   logic [3:0] dig_in;
   logic [2:0] cmd_frame;
   logic [2:0] cmd_sdata;
   logic [2:0] adc_chan;
   logic adc_sdata;
   int n_fail = 0;
   int check_count = 0;
   int rk = 0;
   int sc = 0;
   always #4 clk = ~clk;
   mcd_data_set u_mcd_data_set (.clk(clk), .rst_n(rst_n),
      .frame_start(frame_start), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_word(cmd_word), .mon_valid(mon_valid),
      .mon_ready(mon_ready), .mon_word(mon_word), .ser_clk(ser_clk),
      .sub_addr(sub_addr), .cmd_frame(cmd_frame), .cmd_sdata(cmd_sdata),
      .mon_active(mon_active), .mon_line(mon_line), .adc_chan(adc_chan),
      .dig_in(dig_in), .adc_sdata(adc_sdata));
   mcd_equip_model u_mcd_equip_model (.ser_clk(ser_clk),
      .mon_active(mon_active), .mon_line(mon_line), .sub_addr(sub_addr),
      .dig_in(dig_in), .adc_sdata(adc_sdata));
   // five interleaved parity bits over body
   function automatic logic [4:0] par(input logic [39:0] b);
      logic [4:0] p;
      p = '0;
      for (int i = 0; i < 40; i++)
         p[i % 5] ^= b[i];
      return p;
   endfunction
   function automatic logic [44:0] mk(input logic [23:0] d,
                                      input logic [15:0] a);
      return {d, a, par({d, a})};
   endfunction
   // expected source data per monitor address
   function automatic logic [23:0] epat(input logic [7:0] a);
      return (a < 8'h40) ? {a, ~a, a} : {4'hA, a, 4'h5, a};
   endfunction
   // fill words: lines 0..2, sub-addresses 0 and 15 among them
   function automatic logic [44:0] cw(input int i);
      return mk(24'hC3_5A00 + 24'(i), 16'(i % 3 * 16 + i * 15 % 16));
   endfunction
   task automatic chk(input logic [44:0] exp, input logic [44:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   // offer a word, held until taken
   task automatic send(input logic [44:0] w);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_word = w;
      while (cmd_ready !== 1'b1)
         @(negedge clk);
      @(posedge clk);
   endtask
   task automatic idle;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_word = ~cmd_word;
   endtask
   // collect one serial command word and match it to its network word
   task automatic recv(input logic [44:0] w);
      logic [23:0] got;
      while (cmd_frame === 3'h0)
         @(negedge clk);
      for (int i = 0; i < 24; i++)
      begin
         @(posedge ser_clk);
         got = {got[22:0], cmd_sdata[w[10:9]]};
      end
      chk({3'h1 << w[10:9], w[8:5], w[44:21]}, {cmd_frame, sub_addr, got});
      while (cmd_frame !== 3'h0)
         @(negedge clk);
   endtask
   task automatic t_fill;
      for (int i = 0; i < 9; i++)
         send(cw(i));
      idle;
      chk(45'h0, 45'(cmd_ready));
      for (int i = 0; i < 9; i++)
         recv(cw(i));
   endtask
   task automatic t_parity;
      send(mk(24'h12_3456, 16'h0013) ^ 45'h1);
      send(mk(24'h65_4321, 16'h0025));
      idle;
      recv(mk(24'h65_4321, 16'h0025));
   endtask
   // take one monitor word after a stall
   task automatic take(input logic [7:0] a);
      logic [39:0] b;
      b = {epat(a), 8'h00, a};
      while (mon_valid !== 1'b1)
         @(negedge clk);
      repeat (3) @(negedge clk);
      chk({b, par(b)}, mon_word);
      mon_ready = 1'b1;
      @(negedge clk);
      mon_ready = 1'b0;
      chk(45'h0, 45'(mon_valid));
   endtask
   task automatic frame(input logic [7:0] a2);
      @(negedge clk);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      take(8'(rk * 7 % 192));
      take(a2);
      rk++;
      sc++;
   endtask
   task automatic t_scan;
      for (int i = 0; i < 3; i++)
         frame(8'(sc));
      repeat (600) @(negedge clk);
      chk(45'h0, 45'({mon_active, mon_valid}));
   endtask
   task automatic ctrl(input logic [8:0] p);
      send(mk(24'(p), 16'h0030));
      idle;
   endtask
   task automatic t_fix;
      ctrl(9'h145);
      frame(8'h45);
      ctrl(9'h1BF);
      frame(8'hBF);
      ctrl(9'h1C0);
      frame(8'hBF);
      ctrl(9'h000);
      frame(8'(sc));
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #500_000;
      n_fail++;
      finish_test;
   end
   initial
   begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_fill;
      t_parity;
      t_scan;
      t_fix;
      finish_test;
   end
endmodule // mcd_data_set_tb_top
bind mcd_data_set mcd_data_set_properties u_mcd_data_set_properties (
   .clk(clk), .rst_n(rst_n), .mon_valid(mon_valid),
   .mon_ready(mon_ready), .mon_word(mon_word), .ser_clk(ser_clk),
   .sub_addr(sub_addr), .cmd_frame(cmd_frame), .cmd_sdata(cmd_sdata),
   .mon_active(mon_active), .mon_line(mon_line), .adc_chan(adc_chan));
